/* core/qpc_pkg.sv */
// Notes on behaviour
// - output window: on-threshold nearer lower limit gives inside window, else outside window
// - counting switches the output one count past a threshold, by direction
// - a preload re-evaluates the output exactly at the threshold value
// - output enable set on an enabled channel: counter owns the output, user writes ignored
// - channel disabled: no counting, output goes to the user value
// - preload selection: active edge loads preload value and sets a readable flag
// - stop-to-run transition loads the preload value (default zero) into the accumulator
// - strobe selection: active edge copies accumulator to strobe register, accumulator untouched
// - two-phase mode counts every edge of either phase, four per cycle
// - phase a leading phase b counts up, lagging counts down
// - counter always wraps: one past upper goes to lower and vice versa
// - single-shot mode, count edge and count direction settings are ignored
// - preload/strobe input edge is selectable, rising by default
// - interval 10..65535 ms, default 1000; net counts stored at each interval end
// - rate register is signed 16-bit and wraps two's-complement on overflow
// - rate is net position change; opposite counts cancel
// - new upper limit must be >= all values; new lower limit <= all values
// - incompatible limits are rejected, old ones kept, limit error code returned
// - limits, thresholds, preload are signed 16-bit; upper strictly above lower
// - direction change takes effect at once, no wait for the interval end
// - phase transitions up to 5 kHz are counted without loss
// - enable, output enable, preload/strobe selection and edge are static-only
// - stopped: counting goes on; output normal, forced off or held per failure setting
package qpc_pkg;
  localparam int unsigned QPC_DW = 16;
  localparam int unsigned QPC_AW = 6;
  localparam logic [5:0] QPC_ADDR_CFG = 6'h00;
  localparam logic [5:0] QPC_ADDR_UPPER = 6'h04;
  localparam logic [5:0] QPC_ADDR_LOWER = 6'h08;
  localparam logic [5:0] QPC_ADDR_ON = 6'h0c;
  localparam logic [5:0] QPC_ADDR_OFF = 6'h10;
  localparam logic [5:0] QPC_ADDR_PRELOAD = 6'h14;
  localparam logic [5:0] QPC_ADDR_TIMEBASE = 6'h18;
  localparam logic [5:0] QPC_ADDR_USER = 6'h1c;
  localparam logic [5:0] QPC_ADDR_ACC = 6'h20;
  localparam logic [5:0] QPC_ADDR_STROBE = 6'h24;
  localparam logic [5:0] QPC_ADDR_RATE = 6'h28;
  localparam logic [5:0] QPC_ADDR_STATUS = 6'h2c;
  localparam logic [5:0] QPC_ADDR_RUN = 6'h30;
  localparam int unsigned QPC_CFG_EN = 0;
  localparam int unsigned QPC_CFG_OUT_EN = 1;
  localparam int unsigned QPC_CFG_SEL_STROBE = 2;
  localparam int unsigned QPC_CFG_EDGE_NEG = 3;
  localparam int unsigned QPC_CFG_FAIL_LSB = 4;
  localparam int unsigned QPC_CFG_W = 9;
  localparam logic [8:0] QPC_CFG_RST = 9'h000;
  localparam logic signed [15:0] QPC_UPPER_RST = 16'sh7fff;
  localparam logic signed [15:0] QPC_LOWER_RST = 16'sh0000;
  localparam logic signed [15:0] QPC_ON_RST = 16'sh7fff;
  localparam logic signed [15:0] QPC_OFF_RST = 16'sh0000;
  localparam logic signed [15:0] QPC_PRELOAD_RST = 16'sh0000;
  localparam logic [15:0] QPC_TB_RST = 16'h03e8;
  localparam logic [15:0] QPC_TB_MIN = 16'h000a;
  localparam logic [1:0] QPC_ERR_NONE = 2'h0;
  localparam logic [1:0] QPC_ERR_LIMIT = 2'h1;
  localparam logic [1:0] QPC_ERR_STATIC = 2'h2;
  localparam logic [1:0] QPC_ERR_RANGE = 2'h3;
  localparam int unsigned QPC_CLK_PERIOD_PS = 4000;
  localparam int unsigned QPC_MS_PS = 1000000000;
  localparam int unsigned QPC_MS_CYCLES = QPC_MS_PS / QPC_CLK_PERIOD_PS;
  localparam int unsigned QPC_MAX_RATE_HZ = 5000;
  typedef enum logic [1:0] {
    qpc_fail_normal,
    qpc_fail_forced_off,
    qpc_fail_hold
  } qpc_fail_e;
endpackage

/* core/qpc_counter.sv */
// The strobed register port and the register offsets were decided locally.
`timescale 1ns/1ps
`default_nettype none
module qpc_counter #(
  parameter int unsigned MS_CYCLES = qpc_pkg::QPC_MS_CYCLES
) (
  input wire logic i_clk, // module clock
  input wire logic i_rst, // async reset, active high
  input wire logic i_phase_a, // phase a pin
  input wire logic i_phase_b, // phase b pin
  input wire logic i_preload_strobe_input, // preload/strobe pin
  input wire logic [qpc_pkg::QPC_AW-1:0] i_addr, // register address
  input wire logic [qpc_pkg::QPC_DW-1:0] i_wdata, // write data
  input wire logic i_wr, // write strobe
  input wire logic i_rd, // read strobe
  output logic [qpc_pkg::QPC_DW-1:0] o_rdata, // read data, cycle after i_rd
  output logic o_counter_output // discrete output pin
);
  import qpc_pkg::*;

  // synchronisers and previous synchronised values
  logic [1:0] a_s;
  logic [1:0] b_s;
  logic [1:0] p_s;
  logic a_q;
  logic b_q;
  logic p_q;
  // configuration
  logic [QPC_CFG_W-1:0] cfg;
  logic signed [15:0] upper;
  logic signed [15:0] lower;
  logic signed [15:0] on_th;
  logic signed [15:0] off_th;
  logic signed [15:0] preload;
  logic [15:0] timebase;
  logic user_out;
  logic run;
  logic run_q;
  // state
  logic signed [15:0] acc;
  logic signed [15:0] strobe_val;
  logic signed [15:0] rate;
  logic signed [15:0] delta;
  logic ctr_state;
  logic pl_flag;
  logic [1:0] err;
  logic [17:0] ms_cnt;
  logic [15:0] tb_cnt;

  logic chan_en;
  logic out_en;
  logic sel_strobe;
  logic edge_neg;
  qpc_fail_e fail_mode;
  logic ps_evt;
  logic pl_evt;
  logic st_evt;
  logic step;
  logic up;
  logic run_rise;
  logic ms_tick;
  logic tb_end;
  logic rate_clr;
  logic signed [15:0] next_acc;
  logic next_state;
  logic signed [15:0] next_delta;
  logic next_out;
  logic upper_ok;
  logic lower_ok;
  logic wd_in_range;
  logic signed [15:0] wd;

  assign chan_en = cfg[QPC_CFG_EN];
  assign out_en = cfg[QPC_CFG_OUT_EN];
  assign sel_strobe = cfg[QPC_CFG_SEL_STROBE];
  assign edge_neg = cfg[QPC_CFG_EDGE_NEG];
  assign fail_mode = qpc_fail_e'(cfg[QPC_CFG_FAIL_LSB+1:QPC_CFG_FAIL_LSB]);
  assign wd = $signed(i_wdata);

  // first stage is read only by the second stage
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      a_s <= 2'h0;
      b_s <= 2'h0;
      p_s <= 2'h0;
      a_q <= 1'b0;
      b_q <= 1'b0;
      p_q <= 1'b0;
    end else begin
      a_s <= {a_s[0], i_phase_a};
      b_s <= {b_s[0], i_phase_b};
      p_s <= {p_s[0], i_preload_strobe_input};
      a_q <= a_s[1];
      b_q <= b_s[1];
      p_q <= p_s[1];
    end
  end

  // edge select; rising is the reset default
  assign ps_evt = chan_en && (edge_neg ? (p_q & ~p_s[1]) : (~p_q & p_s[1]));
  assign pl_evt = ps_evt && !sel_strobe;
  assign st_evt = ps_evt && sel_strobe;

  // one count per edge of either phase; both at once is an illegal jump and is dropped.
  // the synchronised path samples every 4 ns, far above any 5 kHz encoder
  assign step = chan_en && ((a_s[1] ^ a_q) ^ (b_s[1] ^ b_q));
  // direction comes from phase order alone, so a reversal acts on the very next edge
  assign up = a_s[1] ^ b_q;

  assign run_rise = run && !run_q;

  function automatic logic in_window(input logic signed [16:0] v,
                                     input logic signed [15:0] on_v,
                                     input logic signed [15:0] off_v);
    logic signed [16:0] on_x;
    logic signed [16:0] off_x;
    on_x = {on_v[15], on_v};
    off_x = {off_v[15], off_v};
    if (on_v <= off_v) begin
      in_window = (v > on_x) && (v <= off_x);
    end else begin
      in_window = (v <= off_x) || (v > on_x);
    end
  endfunction

  always_comb begin
    next_acc = acc;
    next_state = ctr_state;
    if (run_rise) begin
      next_acc = preload;
      next_state = in_window({preload[15], preload}, on_th, off_th);
    end else if (pl_evt) begin
      next_acc = preload;
      // a jump lands exactly on the threshold, no one-past offset
      next_state = in_window({preload[15], preload}, on_th, off_th);
    end else if (step) begin
      if (up) begin
        next_acc = (acc == upper) ? lower : acc + 16'sh0001;
        next_state = in_window({next_acc[15], next_acc}, on_th, off_th);
      end else begin
        next_acc = (acc == lower) ? upper : acc - 16'sh0001;
        // judge one count higher so falling edges switch at n-1
        next_state = in_window({next_acc[15], next_acc} + 17'sh00001, on_th, off_th);
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      acc <= QPC_PRELOAD_RST;
      ctr_state <= 1'b0;
      run_q <= 1'b0;
    end else begin
      acc <= next_acc;
      ctr_state <= next_state;
      run_q <= run;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      strobe_val <= 16'sh0000;
    end else if (st_evt) begin
      strobe_val <= acc;
    end
  end

  // rate measurement: millisecond prescaler, then the interval in ms
  assign ms_tick = (ms_cnt == 18'(MS_CYCLES - 1));
  assign tb_end = ms_tick && (tb_cnt == timebase - 16'h0001);
  assign next_delta = step ? (up ? delta + 16'sh0001 : delta - 16'sh0001) : delta;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ms_cnt <= 18'h0;
      tb_cnt <= 16'h0;
      delta <= 16'sh0000;
      rate <= 16'sh0000;
    end else if (rate_clr || run_rise) begin
      ms_cnt <= 18'h0;
      tb_cnt <= 16'h0;
      delta <= 16'sh0000;
      rate <= 16'sh0000;
    end else begin
      ms_cnt <= ms_tick ? 18'h0 : ms_cnt + 18'h1;
      if (tb_end) begin
        tb_cnt <= 16'h0;
        rate <= next_delta;
        delta <= 16'sh0000;
      end else begin
        tb_cnt <= ms_tick ? tb_cnt + 16'h0001 : tb_cnt;
        delta <= next_delta;
      end
    end
  end

  // limit checks against every dependent value
  assign upper_ok = (wd > lower) && (wd >= on_th) && (wd >= off_th) &&
                    (wd >= preload) && (wd >= acc);
  assign lower_ok = (wd < upper) && (wd <= on_th) && (wd <= off_th) &&
                    (wd <= preload) && (wd <= acc);
  assign wd_in_range = (wd >= lower) && (wd <= upper);
  // a limit or interval change restarts the rate measurement; thresholds and preload do not
  assign rate_clr = i_wr && ((i_addr == QPC_ADDR_UPPER && upper_ok) ||
                    (i_addr == QPC_ADDR_LOWER && lower_ok) ||
                    (i_addr == QPC_ADDR_TIMEBASE && i_wdata >= QPC_TB_MIN));

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cfg <= QPC_CFG_RST;
      upper <= QPC_UPPER_RST;
      lower <= QPC_LOWER_RST;
      on_th <= QPC_ON_RST;
      off_th <= QPC_OFF_RST;
      preload <= QPC_PRELOAD_RST;
      timebase <= QPC_TB_RST;
      user_out <= 1'b0;
      run <= 1'b0;
      err <= QPC_ERR_NONE;
    end else if (i_wr) begin
      if (i_addr == QPC_ADDR_CFG) begin
        // static settings only change while stopped; a running request is refused
        if (run) begin
          err <= QPC_ERR_STATIC;
        end else begin
          cfg <= i_wdata[QPC_CFG_W-1:0];
          err <= QPC_ERR_NONE;
        end
      end else if (i_addr == QPC_ADDR_UPPER) begin
        if (upper_ok) begin
          upper <= wd;
          err <= QPC_ERR_NONE;
        end else begin
          err <= QPC_ERR_LIMIT;
        end
      end else if (i_addr == QPC_ADDR_LOWER) begin
        if (lower_ok) begin
          lower <= wd;
          err <= QPC_ERR_NONE;
        end else begin
          err <= QPC_ERR_LIMIT;
        end
      end else if (i_addr == QPC_ADDR_ON || i_addr == QPC_ADDR_OFF ||
                   i_addr == QPC_ADDR_PRELOAD) begin
        if (wd_in_range) begin
          on_th <= (i_addr == QPC_ADDR_ON) ? wd : on_th;
          off_th <= (i_addr == QPC_ADDR_OFF) ? wd : off_th;
          preload <= (i_addr == QPC_ADDR_PRELOAD) ? wd : preload;
          err <= QPC_ERR_NONE;
        end else begin
          err <= QPC_ERR_RANGE;
        end
      end else if (i_addr == QPC_ADDR_TIMEBASE) begin
        if (i_wdata >= QPC_TB_MIN) begin
          timebase <= i_wdata;
          err <= QPC_ERR_NONE;
        end else begin
          err <= QPC_ERR_RANGE;
        end
      end else if (i_addr == QPC_ADDR_USER) begin
        user_out <= i_wdata[0];
      end else if (i_addr == QPC_ADDR_RUN) begin
        run <= i_wdata[0];
      end
    end
  end

  // preload flag: a new event in the clearing cycle wins
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      pl_flag <= 1'b0;
    end else begin
      pl_flag <= pl_evt || (pl_flag &&
                 !(i_wr && i_addr == QPC_ADDR_STATUS && i_wdata[0]));
    end
  end

  always_comb begin
    if (!chan_en || !out_en) begin
      next_out = user_out;
    end else if (run) begin
      next_out = ctr_state;
    end else begin
      case (fail_mode)
        qpc_fail_forced_off: next_out = 1'b0;
        qpc_fail_hold: next_out = o_counter_output;
        default: next_out = ctr_state;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_counter_output <= 1'b0;
    end else begin
      o_counter_output <= next_out;
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 16'h0000;
    end else if (!i_rd) begin
      o_rdata <= 16'h0000;
    end else if (i_addr == QPC_ADDR_CFG) begin
      o_rdata <= 16'(cfg);
    end else if (i_addr == QPC_ADDR_UPPER) begin
      o_rdata <= upper;
    end else if (i_addr == QPC_ADDR_LOWER) begin
      o_rdata <= lower;
    end else if (i_addr == QPC_ADDR_ON) begin
      o_rdata <= on_th;
    end else if (i_addr == QPC_ADDR_OFF) begin
      o_rdata <= off_th;
    end else if (i_addr == QPC_ADDR_PRELOAD) begin
      o_rdata <= preload;
    end else if (i_addr == QPC_ADDR_TIMEBASE) begin
      o_rdata <= timebase;
    end else if (i_addr == QPC_ADDR_USER) begin
      o_rdata <= {15'h0000, user_out};
    end else if (i_addr == QPC_ADDR_ACC) begin
      o_rdata <= acc;
    end else if (i_addr == QPC_ADDR_STROBE) begin
      o_rdata <= strobe_val;
    end else if (i_addr == QPC_ADDR_RATE) begin
      o_rdata <= rate;
    end else if (i_addr == QPC_ADDR_STATUS) begin
      o_rdata <= {13'h0000, err, pl_flag};
    end else if (i_addr == QPC_ADDR_RUN) begin
      o_rdata <= {15'h0000, run};
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  a_user_owns_out: assert property (@(posedge i_clk) disable iff (i_rst)
    !(chan_en && out_en) |=> o_counter_output == $past(user_out))
    else $error("output not under user control");

  a_preload_load: assert property (@(posedge i_clk) disable iff (i_rst)
    pl_evt && !run_rise |=> acc == $past(preload) && pl_flag)
    else $error("preload event missed");

  a_run_init: assert property (@(posedge i_clk) disable iff (i_rst)
    run && !run_q |=> acc == $past(preload))
    else $error("accumulator not initialised on run");

  a_strobe_capture: assert property (@(posedge i_clk) disable iff (i_rst)
    st_evt |=> strobe_val == $past(acc))
    else $error("strobe did not capture accumulator");

  a_count_up_step: assert property (@(posedge i_clk) disable iff (i_rst)
    step && up && !pl_evt && !run_rise && acc != upper |=> acc == $past(acc) + 16'sh0001)
    else $error("up count wrong");

  a_wrap_top: assert property (@(posedge i_clk) disable iff (i_rst)
    step && up && !pl_evt && !run_rise && acc == upper |=> acc == $past(lower))
    else $error("no wrap at upper limit");

  a_limit_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == QPC_ADDR_UPPER && !upper_ok |=>
      upper == $past(upper) && err == QPC_ERR_LIMIT)
    else $error("bad upper limit accepted");

  a_limit_order: assert property (@(posedge i_clk) disable iff (i_rst)
    upper > lower)
    else $error("upper limit not above lower");

  a_rate_store: assert property (@(posedge i_clk) disable iff (i_rst)
    tb_end && !rate_clr && !run_rise |=> rate == $past(next_delta) && delta == 16'sh0000)
    else $error("rate not stored at interval end");

  a_static_reject: assert property (@(posedge i_clk) disable iff (i_rst)
    i_wr && i_addr == QPC_ADDR_CFG && run |=> cfg == $past(cfg) && err == QPC_ERR_STATIC)
    else $error("static setting changed while running");

  a_forced_off: assert property (@(posedge i_clk) disable iff (i_rst)
    chan_en && out_en && !run && fail_mode == qpc_fail_forced_off |=> !o_counter_output)
    else $error("output not forced off while stopped");
endmodule
`default_nettype wire

/* bench/qpc_enc_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qpc_enc_model (
  input wire logic i_clk, // module clock, paces the steps
  output logic o_phase_a, // phase a pin
  output logic o_phase_b // phase b pin
);
  logic [1:0] pos = 2'h0;

  // gray order 00,10,11,01 upward keeps phase a a quarter cycle ahead of phase b
  assign o_phase_a = pos[0] ^ pos[1];
  assign o_phase_b = pos[1];

  task automatic step(input logic up);
    @(posedge i_clk);
    pos <= up ? pos + 2'h1 : pos - 2'h1;
    // only one phase moves per step, and the gap clears the sync chain; at 9 clocks per step it runs far above 5 kHz
    repeat (8) @(posedge i_clk);
  endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
  import qpc_pkg::*;
  // short millisecond so a 10 ms interval lasts 40 clocks
  localparam int unsigned MSC = 4;
  logic i_clk = 1'b0;
  logic i_rst = 1'b1;
  logic i_preload_strobe_input = 1'b0;
  logic [QPC_AW-1:0] i_addr = '0;
  logic [QPC_DW-1:0] i_wdata = '0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [QPC_DW-1:0] o_rdata;
  logic o_counter_output;
  logic phase_a;
  logic phase_b;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cycles = 0;

  always #2 i_clk = ~i_clk;

  qpc_enc_model enc (.i_clk(i_clk), .o_phase_a(phase_a), .o_phase_b(phase_b));

  qpc_counter #(.MS_CYCLES(MSC)) dut (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_phase_a(phase_a),
    .i_phase_b(phase_b),
    .i_preload_strobe_input(i_preload_strobe_input),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .o_counter_output(o_counter_output)
  );

  task automatic complete_run();
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask

  // the whole run needs about 460 clocks
  always @(posedge i_clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: timeout", $time);
      complete_run();
    end
  end

  task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: word got %h exp %h", $time, got, exp);
    end
  endtask

  // output is registered behind the state update, so let it settle first
  task automatic chk_out(input logic exp);
    repeat (3) @(posedge i_clk);
    #1;
    cmp_count++;
    if (o_counter_output !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: output got %b exp %b", $time, o_counter_output, exp);
    end
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask

  task automatic rd_check(input logic [5:0] a, input logic [15:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    chk_word(o_rdata, exp);
  endtask

  task automatic steps(input int n, input logic up);
    repeat (n) enc.step(up);
  endtask

  task automatic pin(input logic v);
    @(posedge i_clk);
    i_preload_strobe_input <= v;
    repeat (8) @(posedge i_clk);
  endtask

  task automatic t_reset();
    rd_check(QPC_ADDR_UPPER, 16'h7fff);
    rd_check(QPC_ADDR_LOWER, 16'h0000);
    rd_check(QPC_ADDR_ON, 16'h7fff);
    rd_check(QPC_ADDR_TIMEBASE, 16'h03e8);
    rd_check(QPC_ADDR_PRELOAD, 16'h0000);
    rd_check(6'h3c, 16'h0000);
    @(posedge i_clk);
    #1;
    chk_word(o_rdata, 16'h0000);
    chk_out(1'b0);
  endtask

  task automatic t_disabled();
    wr(QPC_ADDR_USER, 16'h0001);
    chk_out(1'b1);
    steps(1, 1'b1);
    rd_check(QPC_ADDR_ACC, 16'h0000);
    wr(QPC_ADDR_CFG, 16'h0001);
    wr(QPC_ADDR_USER, 16'h0000);
    chk_out(1'b0);
  endtask

  task automatic t_window();
    wr(QPC_ADDR_CFG, 16'h0003);
    wr(QPC_ADDR_ON, 16'h0002);
    wr(QPC_ADDR_OFF, 16'h0005);
    wr(QPC_ADDR_UPPER, 16'h000a);
    wr(QPC_ADDR_RUN, 16'h0001);
    rd_check(QPC_ADDR_ACC, 16'h0000);
    wr(QPC_ADDR_USER, 16'h0001);
    chk_out(1'b0);
    steps(3, 1'b1);
    rd_check(QPC_ADDR_ACC, 16'h0003);
    chk_out(1'b1);
    steps(3, 1'b1);
    chk_out(1'b0);
    steps(1, 1'b0);
    rd_check(QPC_ADDR_ACC, 16'h0005);
    chk_out(1'b0);
    steps(1, 1'b0);
    chk_out(1'b1);
  endtask

  task automatic t_wrap();
    steps(6, 1'b1);
    rd_check(QPC_ADDR_ACC, 16'h000a);
    steps(1, 1'b1);
    rd_check(QPC_ADDR_ACC, 16'h0000);
    steps(1, 1'b0);
    rd_check(QPC_ADDR_ACC, 16'h000a);
  endtask

  task automatic t_limits();
    wr(QPC_ADDR_UPPER, 16'h0009);
    rd_check(QPC_ADDR_UPPER, 16'h000a);
    rd_check(QPC_ADDR_STATUS, 16'h0002);
    wr(QPC_ADDR_LOWER, 16'h0003);
    rd_check(QPC_ADDR_LOWER, 16'h0000);
    wr(QPC_ADDR_CFG, 16'h0000);
    rd_check(QPC_ADDR_STATUS, 16'h0004);
    rd_check(QPC_ADDR_CFG, 16'h0003);
  endtask

  task automatic t_preload();
    wr(QPC_ADDR_PRELOAD, 16'h0005);
    chk_out(1'b0);
    pin(1'b1);
    rd_check(QPC_ADDR_ACC, 16'h0005);
    chk_out(1'b1);
    rd_check(QPC_ADDR_STATUS, 16'h0001);
    pin(1'b0);
  endtask

  task automatic t_rate();
    wr(QPC_ADDR_TIMEBASE, 16'h000a);
    steps(3, 1'b1);
    steps(1, 1'b0);
    // lands in the second interval, so the first one's net change is on show
    repeat (30) @(posedge i_clk);
    rd_check(QPC_ADDR_RATE, 16'h0002);
  endtask

  task automatic t_fail();
    wr(QPC_ADDR_RUN, 16'h0000);
    wr(QPC_ADDR_CFG, 16'h0013);
    chk_out(1'b0);
    steps(1, 1'b1);
    rd_check(QPC_ADDR_ACC, 16'h0008);
    wr(QPC_ADDR_RUN, 16'h0001);
    rd_check(QPC_ADDR_ACC, 16'h0005);
    chk_out(1'b1);
    wr(QPC_ADDR_RUN, 16'h0000);
    chk_out(1'b0);
    // hold mode: stop while the output is on, then count out of the window
    wr(QPC_ADDR_CFG, 16'h0023);
    wr(QPC_ADDR_RUN, 16'h0001);
    wr(QPC_ADDR_RUN, 16'h0000);
    steps(1, 1'b1);
    chk_out(1'b1);
    rd_check(QPC_ADDR_ACC, 16'h0006);
  endtask

  task automatic t_strobe();
    wr(QPC_ADDR_CFG, 16'h01cf);
    wr(QPC_ADDR_RUN, 16'h0001);
    steps(2, 1'b1);
    pin(1'b1);
    rd_check(QPC_ADDR_STROBE, 16'h0000);
    pin(1'b0);
    rd_check(QPC_ADDR_STROBE, 16'h0007);
    rd_check(QPC_ADDR_ACC, 16'h0007);
  endtask

  initial begin
    repeat (20) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset();
    t_disabled();
    t_window();
    t_wrap();
    t_limits();
    t_preload();
    t_rate();
    t_fail();
    t_strobe();
    complete_run();
  end
endmodule
`default_nettype wire
